// File: dv/comp_model.sv
// comparator in front of the approximation logic; keeps a trial
// when it does not exceed the held input level
module comp_model
  import sar_ctrl_pkg::*;
(
  // trial word and held level
  input wire logic [sar_ctrl_pkg::RESULT_W-1:0] trial_code,
  input wire logic [sar_ctrl_pkg::RESULT_W-1:0] level,
  // decision
  output logic comp_hi
);
  timeunit 1ns;
  timeprecision 1ns;
  // level is steady for a whole conversion, so the answer never flickers
  assign comp_hi = (trial_code <= level);
endmodule : comp_model

// File: dv/test_sar_adc_conversion_control.sv
module test_sar_adc_conversion_control;
  timeunit 1ns;
  timeprecision 1ns;
  import sar_ctrl_pkg::*;
  logic clk, rst_n, ce, cs_n, rc, lbs, wws, comp_hi, hold, busy;
  logic [RESULT_W-1:0] trial_code, data_out, data_oe, level;
  int errors = 0;
  int samples_checked = 0;

  sar_adc_conversion_control dut (.clk(clk), .rst_n(rst_n), .chip_enable(ce),
    .chip_select_n(cs_n), .read_convert(rc), .length_byte_select(lbs),
    .word_width_select(wws), .comp_hi(comp_hi), .hold(hold), .trial_code(trial_code),
    .busy(busy), .data_out(data_out), .data_oe(data_oe));
  comp_model analog (.trial_code(trial_code), .level(level), .comp_hi(comp_hi));

  // free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic chk(input logic [RESULT_W-1:0] got, input logic [RESULT_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // bounded wait so a stuck busy shows up as a mismatch, not a hang
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      tick(1);
      n++;
    end
    chk({11'h0, busy}, {11'h0, lvl});
  endtask : wait_busy

  // way 0: convert line falls, 1: select falls, 2: enable rises
  task automatic convert(input int way, input logic len, input logic [RESULT_W-1:0] tgt);
    tick(1);
    level = tgt;
    lbs = len;
    ce = (way != 2);
    cs_n = (way == 1);
    rc = (way == 0);
    tick(4); // others settle well before the deciding edge
    if (way == 0) rc = 1'b0;
    else if (way == 1) cs_n = 1'b0;
    else ce = 1'b1;
    tick(3); // convert held low past its minimum
    wait_busy(1'b1, 10);
    chk({11'h0, hold}, 12'h001);
    chk(data_oe, 12'h000);
    lbs = ~len; // a later start would latch this
    rc = 1'b1;
    tick(3);
    chk(data_oe, 12'h000);
    rc = 1'b0; // pulse during busy must not restart
    tick(3);
    rc = 1'b1;
    tick(3);
    wait_busy(1'b0, THROUGHPUT_CYC);
    chk({11'h0, hold}, 12'h000);
    lbs = 1'b0;
    wws = 1'b1;
    tick(3);
    chk(data_oe, 12'hFFF);
    chk(data_out, len ? {tgt[11:4], 4'h0} : tgt);
  endtask : convert

  task automatic t_standalone();
    convert(0, 1'b0, 12'hA5C);
    convert(0, 1'b0, 12'h000);
  endtask : t_standalone

  task automatic t_short_select();
    convert(1, 1'b1, 12'h5A7);
  endtask : t_short_select

  task automatic t_enable_start();
    convert(2, 1'b0, 12'hFFF);
  endtask : t_enable_start

  task automatic t_readout();
    wws = 1'b0;
    tick(3);
    chk(data_oe, 12'h0FF);
    chk(data_out, 12'h0FF);
    lbs = 1'b1;
    tick(3);
    chk(data_oe, 12'h0FF);
    chk(data_out, 12'h0F0);
    ce = 1'b0;
    tick(3);
    chk(data_oe, 12'h000);
    ce = 1'b1;
    cs_n = 1'b1;
    tick(3);
    chk(data_oe, 12'h000);
  endtask : t_readout

  task automatic summarize();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // watchdog: four conversions need about 1650 cycles
  initial begin
    repeat (10000) @(posedge clk);
    errors++;
    summarize();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    cs_n = 1'b0;
    rc = 1'b1;
    lbs = 1'b0;
    wws = 1'b1;
    level = 12'h000;
    tick(10);
    rst_n = 1'b1;
    tick(3);
    t_standalone();
    t_short_select();
    t_enable_start();
    t_readout();
    summarize();
  end
endmodule : test_sar_adc_conversion_control

// File: shared/sar_ctrl_pkg.sv
package sar_ctrl_pkg;
  localparam int RESULT_W = 12;
  localparam int SHORT_BITS = 8;
  localparam int LOW_BITS = 4;
  localparam int CLK_HZ = 50_000_000;
  // worst-case conversion plus reacquisition, in nanoseconds
  localparam int THROUGHPUT_NS = 8500;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // longest time rounds down
  localparam int THROUGHPUT_CYC = THROUGHPUT_NS / CLK_PERIOD_NS;
  // reacquisition window after the last bit, in nanoseconds
  localparam int ACQUIRE_NS = 1500;
  localparam int ACQUIRE_CYC = (ACQUIRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // cycles per bit step: what remains split over twelve steps, rounded down
  localparam int BIT_CYC = (THROUGHPUT_CYC - ACQUIRE_CYC) / RESULT_W;
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
  localparam logic [4:0] BIT_CYC_W5 = 5'(BIT_CYC);
endpackage : sar_ctrl_pkg

// File: shared/sar_step_if.sv
// link between sequencer and approximation register
interface sar_step_if;
  logic start;
  logic step;
  logic short_mode;
  logic comp_hi;
  logic [sar_ctrl_pkg::RESULT_W-1:0] trial;
  logic done;
  logic [sar_ctrl_pkg::RESULT_W-1:0] result;
  modport seq (output start, output step, output short_mode, input done, input result,
    input trial);
  modport sar (input start, input step, input short_mode, input comp_hi, output trial,
    output done, output result);
endinterface : sar_step_if

// File: src/sar_adc_conversion_control.sv
// Functional notes
// - falling read/convert starts hold and conversion
// - busy high until result latched on outputs
// - data pins high-impedance during conversion
// - starts ignored while busy is high
// - reacquire after conversion, before busy falls
// - conversion plus acquisition within 8.5us
// - 8/12-bit length, word or byte reads
// - stand-alone outputs on when read high, idle
// - convert pulse blanks outputs until conversion done
// - positive pulse reads old result, then converts
// - length select latched at accepted start
// - short conversion reads low four bits zero
// - only length select is latched
// - approximate bits from msb downward
// - start on last of three conditions completing
// - outputs enabled only when all four conditions
// - word width picks all, high or low byte
module sar_adc_conversion_control (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control pins
  input wire logic chip_enable,
  input wire logic chip_select_n,
  input wire logic read_convert,
  input wire logic length_byte_select,
  input wire logic word_width_select,
  // comparator from the analog array
  input wire logic comp_hi,
  // analog switch control
  output logic hold,
  output logic [sar_ctrl_pkg::RESULT_W-1:0] trial_code,
  // status and three-state data
  output logic busy,
  output logic [sar_ctrl_pkg::RESULT_W-1:0] data_out,
  output logic [sar_ctrl_pkg::RESULT_W-1:0] data_oe
);
  import sar_ctrl_pkg::*;

  typedef enum logic [1:0] {
    ST_TRACK = 2'b00,
    ST_CONV = 2'b01,
    ST_ACQ = 2'b10
  } phase_e;

  typedef struct packed {
    logic [1:0] ce_sync;
    logic [1:0] cs_sync;
    logic [1:0] rc_sync;
    logic [1:0] ab_sync;
    logic [1:0] ww_sync;
    logic [1:0] cmp_sync;
    logic go_prev;
    phase_e phase;
    logic short_mode;
    logic [4:0] bit_cnt;
    logic [7:0] acq_cnt;
    logic [RESULT_W-1:0] result;
    logic start;
    logic step;
    logic hold;
    logic busy;
    logic [RESULT_W-1:0] dout;
    logic [RESULT_W-1:0] doe;
  } ctrl_s;

  ctrl_s st_reg;
  ctrl_s st_next;
  sar_step_if link ();

  // pick lanes for word or byte reads
  // byte reads place either byte on the low eight lanes, so one mask serves both bytes
  function automatic logic [RESULT_W-1:0] lane_mask(input logic ww);
    lane_mask = ww ? {RESULT_W{1'b1}} : 12'h0FF;
  endfunction : lane_mask

  function automatic logic [RESULT_W-1:0] lane_data(input logic ww, input logic ab,
      input logic [RESULT_W-1:0] r);
    if (ww) begin
      lane_data = r;
    end else if (ab) begin
      lane_data = {4'h0, r[LOW_BITS-1:0], 4'h0}; // low nibble then trailing zeros
    end else begin
      lane_data = {4'h0, r[RESULT_W-1:LOW_BITS]};
    end
  endfunction : lane_data

  logic ce_s;
  logic cs_n_s;
  logic rc_s;
  logic go_now;
  logic read_ok;
  assign ce_s = st_reg.ce_sync[1];
  assign cs_n_s = st_reg.cs_sync[1];
  assign rc_s = st_reg.rc_sync[1];
  // start condition, whichever input completes it last
  assign go_now = ce_s && !cs_n_s && !rc_s;
  // read window needs all four conditions at once, no latching
  assign read_ok = rc_s && !st_reg.busy && ce_s && !cs_n_s;

  assign link.start = st_reg.start;
  assign link.step = st_reg.step;
  assign link.short_mode = st_reg.short_mode;
  assign link.comp_hi = st_reg.cmp_sync[1];

  // sequencer: start, step timing, reacquire, then release busy
  always_comb begin
    st_next = st_reg;
    st_next.ce_sync = {st_reg.ce_sync[0], chip_enable};
    st_next.cs_sync = {st_reg.cs_sync[0], chip_select_n};
    st_next.rc_sync = {st_reg.rc_sync[0], read_convert};
    st_next.ab_sync = {st_reg.ab_sync[0], length_byte_select};
    st_next.ww_sync = {st_reg.ww_sync[0], word_width_select};
    st_next.cmp_sync = {st_reg.cmp_sync[0], comp_hi};
    st_next.go_prev = go_now;
    st_next.start = 1'b0;
    st_next.step = 1'b0;
    case (st_reg.phase)
      ST_TRACK: begin
        st_next.hold = 1'b0;
        // the pulse width is only as short as two synchroniser edges can see
        if (go_now && !st_reg.go_prev) begin
          st_next.phase = ST_CONV;
          st_next.short_mode = st_reg.ab_sync[1];
          st_next.hold = 1'b1;
          st_next.busy = 1'b1;
          st_next.start = 1'b1;
          st_next.bit_cnt = BIT_CYC_W5;
        end
      end
      ST_CONV: begin
        // further start edges fall through here unseen
        if (link.done) begin
          st_next.result = link.result;
          st_next.hold = 1'b0; // acquire before busy falls
          st_next.phase = ST_ACQ;
          // three cycles trimmed to cover synchroniser and done latency
          st_next.acq_cnt = 8'(ACQUIRE_CYC - 3);
        end else if (st_reg.bit_cnt == 5'd1) begin
          st_next.step = 1'b1;
          st_next.bit_cnt = BIT_CYC_W5;
        end else begin
          st_next.bit_cnt = st_reg.bit_cnt - 5'd1;
        end
      end
      ST_ACQ: begin
        // result already latched, tracking runs meanwhile
        if (st_reg.acq_cnt <= 8'd1) begin
          st_next.busy = 1'b0;
          st_next.phase = ST_TRACK;
        end else begin
          st_next.acq_cnt = st_reg.acq_cnt - 8'd1;
        end
      end
      default: begin
        st_next.phase = ST_TRACK;
        st_next.busy = 1'b0;
      end
    endcase
    // outputs blank whenever busy or read window closed
    if (read_ok && !st_next.busy) begin
      st_next.doe = lane_mask(st_reg.ww_sync[1]);
      st_next.dout = lane_data(st_reg.ww_sync[1], st_reg.ab_sync[1], st_reg.result);
    end else begin
      st_next.doe = '0;
      st_next.dout = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  sar_approx u_approx (
    .clk(clk),
    .rst_n(rst_n),
    .link(link.sar)
  );

  assign hold = st_reg.hold;
  assign busy = st_reg.busy;
  assign data_out = st_reg.dout;
  assign data_oe = st_reg.doe;
  assign trial_code = link.trial;

  a_busy_blanks: assert property (@(posedge clk) disable iff (!rst_n)
    busy |-> data_oe == '0)
    else $error("data driven while busy");
  a_start_busy: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.phase == ST_TRACK && go_now && !st_reg.go_prev) |=> busy && hold)
    else $error("start did not raise busy");
  a_ignore_starts: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.phase == ST_CONV && !link.done) |=> st_reg.phase == ST_CONV)
    else $error("conversion restarted");
  a_len_latched: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.phase == ST_CONV) |=> $stable(st_reg.short_mode))
    else $error("length changed mid conversion");
  a_reacq_early: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(busy) |-> $past(hold) == 1'b0)
    else $error("busy fell while holding");
  a_conv_bound: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(busy) |-> ##[1:425] !busy)
    else $error("conversion too long");
  a_read_window: assert property (@(posedge clk) disable iff (!rst_n)
    (data_oe != '0) |-> $past(read_ok))
    else $error("outputs on outside read window");
  a_result_stable: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(busy) |-> $stable(st_reg.result))
    else $error("result moved at busy fall");
endmodule : sar_adc_conversion_control

// File: src/sar_approx.sv
module sar_approx (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sequencer link
  sar_step_if.sar link
);
  import sar_ctrl_pkg::*;

  typedef struct packed {
    logic [RESULT_W-1:0] acc;
    logic [RESULT_W-1:0] probe;
    logic done;
  } approx_s;

  approx_s st_reg;
  approx_s st_next;

  // msb first: keep or clear the probed bit, then probe the next one down
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (link.start) begin
      st_next.acc = {1'b1, {(RESULT_W-1){1'b0}}};
      st_next.probe = {1'b1, {(RESULT_W-1){1'b0}}};
    end else if (link.step && st_reg.probe != '0) begin
      if (!link.comp_hi) begin
        st_next.acc = st_reg.acc & ~st_reg.probe;
      end
      st_next.probe = st_reg.probe >> 1;
      // short cycle stops after eight bits, low bits stay zero
      if (st_reg.probe[0] || (link.short_mode && st_reg.probe[LOW_BITS])) begin
        st_next.probe = '0;
        st_next.done = 1'b1;
      end else begin
        st_next.acc = (link.comp_hi ? st_reg.acc : st_reg.acc & ~st_reg.probe)
          | (st_reg.probe >> 1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.trial = st_reg.acc;
  assign link.result = st_reg.acc;
  assign link.done = st_reg.done;

  a_short_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (link.done && link.short_mode) |-> link.result[LOW_BITS-1:0] == '0)
    else $error("short conversion left low bits set");
endmodule : sar_approx
